// file: logic/iopim_pkg.sv
/*
 Shared constants, types and decode functions for the process image mapper.
 Assumes word-addressed process images with 16-bit words, low byte in lane 0.
*/
package iopim_pkg;

   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int LANES = 2;
   localparam int LANE_LO = 0;
   localparam int LANE_HI = 1;
   localparam int DO_CH = 8;
   localparam int AI_CH_MAX = 4;
   localparam int AO_CH_MAX = 4;
   localparam int AI_SINGLE_WORDS = 2;
   localparam int AI_DIFF_IDX = 0;
   localparam int AI_REF_IDX = 1;
   localparam int ADDR_W = 3;
   localparam int IMAGE_WORDS_MAX = 6;

   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_PAD = 8'h00;
   localparam logic FLAG_NONE = 1'b0;
   localparam logic FLAG_FAULT = 1'b1;

   typedef enum {
      IOPIM_RG_ANALOG,
      IOPIM_RG_SPECIAL,
      IOPIM_RG_DIGITAL,
      IOPIM_RG_NONE
   } iopim_region_t;

   // A one-channel input module occupies two words, the others one per channel
   function automatic int iopim_ai_words(input int ch);
      iopim_ai_words = (ch == 1) ? AI_SINGLE_WORDS : ch;
   endfunction : iopim_ai_words

   // Analog words first, then the optional control/status word, digital byte last
   function automatic iopim_region_t iopim_region(input logic [ADDR_W-1:0] a,
                                                  input int words, input int spec);
      int ai;
      ai = int'(a);
      if (ai < words) begin
         iopim_region = IOPIM_RG_ANALOG;
      end else if ((spec != 0) && (ai == words)) begin
         iopim_region = IOPIM_RG_SPECIAL;
      end else if (ai == words + spec) begin
         iopim_region = IOPIM_RG_DIGITAL;
      end else begin
         iopim_region = IOPIM_RG_NONE;
      end
   endfunction : iopim_region

   function automatic logic [WORD_W-1:0] iopim_byte_word(input logic [BYTE_W-1:0] b);
      iopim_byte_word = {BYTE_PAD, b};
   endfunction : iopim_byte_word

endpackage : iopim_pkg

// file: logic/iopim_fault_flags.sv
/*
 Per-channel fault flags of the switched-output module.
 Assumes fault inputs are synchronous levels from the output drivers.
*/
`timescale 1ns/100ps
module iopim_fault_flags #(
   parameter int CH = iopim_pkg::DO_CH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [CH-1:0] overload,
   input wire logic [CH-1:0] short_circuit,
   input wire logic [CH-1:0] open_wire,
   output logic [CH-1:0] flags_q
);

   logic [CH-1:0] flags_d;

   generate
      if (CH < 1) begin : g_bad_ch
         $error("iopim_fault_flags: CH must be at least 1");
      end
   endgenerate

   // Flag follows the fault condition so a cleared fault reads as no error
   assign flags_d = overload | short_circuit | open_wire; // [R1] [R2]

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= '0; // [R14]
      end else begin
         flags_q <= flags_d; // [R1]
      end
   end

endmodule : iopim_fault_flags

// file: logic/iopim_word_store.sv
/*
 Small word memory holding the output process image.
 Assumes one write and one read per cycle; read data come from a register.
*/
`timescale 1ns/100ps
module iopim_word_store #(
   parameter int DEPTH = iopim_pkg::IMAGE_WORDS_MAX
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wr_en,
   input wire logic [iopim_pkg::ADDR_W-1:0] wr_idx,
   input wire logic [iopim_pkg::LANES-1:0] wr_be,
   input wire logic [iopim_pkg::WORD_W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [iopim_pkg::ADDR_W-1:0] rd_idx,
   output logic [iopim_pkg::WORD_W-1:0] rd_data_q,
   output logic [DEPTH*iopim_pkg::WORD_W-1:0] flat_q
);

   logic [iopim_pkg::WORD_W-1:0] mem_q [DEPTH];
   logic rd_hit;

   generate
      if ((DEPTH < 1) || (DEPTH > (1 << iopim_pkg::ADDR_W))) begin : g_bad_depth
         $error("iopim_word_store: DEPTH out of range");
      end
   endgenerate

   assign rd_hit = int'(rd_idx) < DEPTH;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= iopim_pkg::WORD_RST; // [R14]
         end
      end else if (wr_en && (int'(wr_idx) < DEPTH)) begin
         for (int l = 0; l < iopim_pkg::LANES; l++) begin
            if (wr_be[l]) begin
               mem_q[wr_idx][l*iopim_pkg::BYTE_W +: iopim_pkg::BYTE_W] <=
                  wr_data[l*iopim_pkg::BYTE_W +: iopim_pkg::BYTE_W];
            end
         end
      end
   end

   // Read of a word written in the same cycle returns the old contents
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_data_q <= iopim_pkg::WORD_RST;
      end else if (rd_en) begin
         rd_data_q <= rd_hit ? mem_q[rd_idx] : iopim_pkg::WORD_RST;
      end
   end

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         flat_q[i*iopim_pkg::WORD_W +: iopim_pkg::WORD_W] = mem_q[i];
      end
   end

endmodule : iopim_word_store

// file: logic/iopim_mapper.sv
/*
 Process image mapper: builds the input image from analog words, specialty
 status and output fault flags, and unpacks the output image into analog
 values, the specialty control byte and the output switching byte.
 Assumes the controller side accesses images word by word, synchronous to clk.
*/
// Notes on behaviour
// [R1] Each of the eight switched outputs keeps one fault flag set by a fault.
// [R2] A fault flag reads 0 for no error, 1 for overload, short or open wire.
// [R3] Fault flags sit in one input byte, bit k for channel k+1.
// [R4] Switching byte from the output image, bit k drives channel k+1.
// [R5] Only 16-bit analog input words are visible, low byte first, status hidden.
// [R6] Analog input words come before the digital byte in the input image.
// [R7] Only 16-bit analog output words are accepted, low byte first, status hidden.
// [R8] Analog output words come before the digital byte in the output image.
// [R9] One-channel input: word 0 differential value, word 1 reference value.
// [R10] Two or four channel input: channel n at word n-1, up to word 3.
// [R11] Two or four channel output: channel n from word n-1, up to word 3.
// [R12] Control byte flows toward the module, status byte back to the controller.
// [R13] Module acts on its control byte and reports conditions in its status byte.
// [R14] After reset all outputs, analog words and fault flags are zero.
`timescale 1ns/100ps
module iopim_mapper #(
   parameter int AI_CH = iopim_pkg::AI_CH_MAX,
   parameter int AO_CH = iopim_pkg::AO_CH_MAX,
   parameter int SPEC_EN = 1,
   localparam int AI_WORDS = iopim_pkg::iopim_ai_words(AI_CH),
   localparam int SPEC_W = (SPEC_EN != 0) ? 1 : 0,
   localparam int OUT_WORDS = AO_CH + SPEC_W + 1,
   localparam int IN_WORDS = AI_WORDS + SPEC_W + 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_rd_en,
   input wire logic [iopim_pkg::ADDR_W-1:0] in_rd_addr,
   output logic [iopim_pkg::WORD_W-1:0] in_rd_data,
   output logic in_rd_valid,
   output logic in_rd_err,
   input wire logic out_wr_en,
   input wire logic [iopim_pkg::ADDR_W-1:0] out_wr_addr,
   input wire logic [iopim_pkg::LANES-1:0] out_wr_be,
   input wire logic [iopim_pkg::WORD_W-1:0] out_wr_data,
   output logic out_wr_err,
   input wire logic out_rd_en,
   input wire logic [iopim_pkg::ADDR_W-1:0] out_rd_addr,
   output logic [iopim_pkg::WORD_W-1:0] out_rd_data,
   output logic out_rd_valid,
   output logic out_rd_err,
   input wire logic [AI_WORDS*iopim_pkg::WORD_W-1:0] ai_meas,
   input wire logic [iopim_pkg::DO_CH-1:0] do_overload,
   input wire logic [iopim_pkg::DO_CH-1:0] do_short,
   input wire logic [iopim_pkg::DO_CH-1:0] do_open,
   input wire logic [iopim_pkg::BYTE_W-1:0] spec_status,
   output logic [AO_CH*iopim_pkg::WORD_W-1:0] ao_value,
   output logic [iopim_pkg::DO_CH-1:0] do_switch,
   output logic [iopim_pkg::BYTE_W-1:0] spec_ctrl,
   output logic spec_ctrl_load
);

   generate
      if ((AI_CH != 1) && (AI_CH != 2) && (AI_CH != iopim_pkg::AI_CH_MAX)) begin : g_bad_ai
         $error("iopim_mapper: AI_CH must be 1, 2 or 4");
      end
      if ((AO_CH != 2) && (AO_CH != iopim_pkg::AO_CH_MAX)) begin : g_bad_ao
         $error("iopim_mapper: AO_CH must be 2 or 4");
      end
      if ((SPEC_EN != 0) && (SPEC_EN != 1)) begin : g_bad_spec
         $error("iopim_mapper: SPEC_EN must be 0 or 1");
      end
      if ((IN_WORDS > iopim_pkg::IMAGE_WORDS_MAX) ||
          (OUT_WORDS > iopim_pkg::IMAGE_WORDS_MAX)) begin : g_bad_size
         $error("iopim_mapper: image larger than the address space");
      end
   endgenerate

   // Fault flags of the switched-output module

   logic [iopim_pkg::DO_CH-1:0] fault_flags;

   iopim_fault_flags #(
      .CH(iopim_pkg::DO_CH)
   ) u_faults (
      .clk(clk),
      .rst_b(rst_b),
      .overload(do_overload),
      .short_circuit(do_short),
      .open_wire(do_open),
      .flags_q(fault_flags)
   );

   // Input image decode

   iopim_pkg::iopim_region_t in_region;
   logic [iopim_pkg::WORD_W-1:0] in_ai_word;
   logic [iopim_pkg::WORD_W-1:0] in_status_word;
   logic [iopim_pkg::WORD_W-1:0] in_diag_word;
   logic [iopim_pkg::WORD_W-1:0] in_sel_word;
   logic in_unmapped;

   assign in_region = iopim_pkg::iopim_region(in_rd_addr, AI_WORDS, SPEC_W); // [R6]
   assign in_unmapped = in_region == iopim_pkg::IOPIM_RG_NONE;

   // One-channel modules deliver the differential word first, reference second
   assign in_ai_word = ai_meas[int'(in_rd_addr)*iopim_pkg::WORD_W +: iopim_pkg::WORD_W]; // [R9] [R10]

   // Module status byte goes back in the low lane, upper lane padded
   assign in_status_word = iopim_pkg::iopim_byte_word(spec_status); // [R12] [R13]

   // Channel k+1 fault flag lands on bit k of the digital byte
   assign in_diag_word = iopim_pkg::iopim_byte_word(fault_flags); // [R3]

   // The analog modules' own control/status bits never reach this mux
   assign in_sel_word = (in_region == iopim_pkg::IOPIM_RG_ANALOG) ? in_ai_word : // [R5]
                        (in_region == iopim_pkg::IOPIM_RG_SPECIAL) ? in_status_word :
                        (in_region == iopim_pkg::IOPIM_RG_DIGITAL) ? in_diag_word :
                        iopim_pkg::WORD_RST;

   logic [iopim_pkg::WORD_W-1:0] in_rd_data_q;
   logic [iopim_pkg::WORD_W-1:0] in_rd_data_d;
   logic in_rd_valid_q;
   logic in_rd_err_q;

   assign in_rd_data_d = in_rd_en ? in_sel_word : in_rd_data_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_rd_data_q <= iopim_pkg::WORD_RST;
         in_rd_valid_q <= 1'b0;
         in_rd_err_q <= 1'b0;
      end else begin
         in_rd_data_q <= in_rd_data_d;
         in_rd_valid_q <= in_rd_en;
         in_rd_err_q <= in_rd_en && in_unmapped;
      end
   end

   assign in_rd_data = in_rd_data_q;
   assign in_rd_valid = in_rd_valid_q;
   assign in_rd_err = in_rd_err_q;

   // Output image decode

   iopim_pkg::iopim_region_t wr_region;
   iopim_pkg::iopim_region_t rd_region;
   logic wr_mapped;
   logic [iopim_pkg::LANES-1:0] wr_be_eff;
   logic wr_go;
   logic ctrl_hit;

   assign wr_region = iopim_pkg::iopim_region(out_wr_addr, AO_CH, SPEC_W); // [R8]
   assign rd_region = iopim_pkg::iopim_region(out_rd_addr, AO_CH, SPEC_W); // [R8]
   assign wr_mapped = wr_region != iopim_pkg::IOPIM_RG_NONE;
   assign wr_go = out_wr_en && wr_mapped;

   // Byte-wide words keep their upper lane at zero so readback stays honest
   assign wr_be_eff = (wr_region == iopim_pkg::IOPIM_RG_ANALOG) ? out_wr_be : // [R7] [R11]
                      {1'b0, out_wr_be[iopim_pkg::LANE_LO]};

   assign ctrl_hit = wr_go && (wr_region == iopim_pkg::IOPIM_RG_SPECIAL) &&
                     out_wr_be[iopim_pkg::LANE_LO];

   logic [OUT_WORDS*iopim_pkg::WORD_W-1:0] out_flat;
   logic [iopim_pkg::WORD_W-1:0] out_rd_word;

   iopim_word_store #(
      .DEPTH(OUT_WORDS)
   ) u_out_image (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(wr_go),
      .wr_idx(out_wr_addr),
      .wr_be(wr_be_eff),
      .wr_data(out_wr_data),
      .rd_en(out_rd_en),
      .rd_idx(out_rd_addr),
      .rd_data_q(out_rd_word),
      .flat_q(out_flat)
   );

   logic out_rd_valid_q;
   logic out_rd_err_q;
   logic out_wr_err_q;
   logic spec_ctrl_load_q;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_rd_valid_q <= 1'b0;
         out_rd_err_q <= 1'b0;
         out_wr_err_q <= 1'b0;
         spec_ctrl_load_q <= 1'b0;
      end else begin
         out_rd_valid_q <= out_rd_en;
         out_rd_err_q <= out_rd_en && (rd_region == iopim_pkg::IOPIM_RG_NONE);
         out_wr_err_q <= out_wr_en && !wr_mapped;
         spec_ctrl_load_q <= ctrl_hit; // [R13]
      end
   end

   assign out_rd_data = out_rd_word;
   assign out_rd_valid = out_rd_valid_q;
   assign out_rd_err = out_rd_err_q;
   assign out_wr_err = out_wr_err_q;

   // Output image unpacking

   // Channel n value is word n-1; the store resets every word to zero
   assign ao_value = out_flat[AO_CH*iopim_pkg::WORD_W-1:0]; // [R7] [R11] [R14]

   // Digital byte is the last word, bit k drives channel k+1
   assign do_switch = out_flat[(OUT_WORDS-1)*iopim_pkg::WORD_W +: iopim_pkg::DO_CH]; // [R4] [R14]

   generate
      if (SPEC_W != 0) begin : g_spec
         // Control byte travels toward the module with a load pulse per write that enables the low lane
         assign spec_ctrl = out_flat[AO_CH*iopim_pkg::WORD_W +: iopim_pkg::BYTE_W]; // [R12]
         assign spec_ctrl_load = spec_ctrl_load_q; // [R13]
      end else begin : g_no_spec
         assign spec_ctrl = iopim_pkg::BYTE_RST;
         assign spec_ctrl_load = 1'b0;
      end
   endgenerate

endmodule : iopim_mapper

// file: testbench/iopim_mapper_asserts.sv
/*
 Concurrent checks on the process image mapper ports.
 Assumes the default map: analog 0-3, special word 4, digital word 5.
*/
`timescale 1ns/100ps
module iopim_mapper_chk #(
   parameter int AO_CH = 4
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_rd_en,
   input wire logic [2:0] in_rd_addr,
   input wire logic [15:0] in_rd_data,
   input wire logic in_rd_valid,
   input wire logic in_rd_err,
   input wire logic out_wr_en,
   input wire logic [2:0] out_wr_addr,
   input wire logic [1:0] out_wr_be,
   input wire logic [15:0] out_wr_data,
   input wire logic out_wr_err,
   input wire logic [7:0] do_overload,
   input wire logic [7:0] do_short,
   input wire logic [7:0] do_open,
   input wire logic [7:0] spec_status,
   input wire logic [AO_CH*16-1:0] ao_value,
   input wire logic [7:0] do_switch,
   input wire logic [7:0] spec_ctrl,
   input wire logic spec_ctrl_load
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   rd_valid_a: assert property (in_rd_en |=> in_rd_valid) else $error("no read valid");
   rd_single_a: assert property (!in_rd_en |=> !in_rd_valid) else $error("stray valid");
   rd_unmap_a: assert property (in_rd_en && in_rd_addr > 3'h5 |=> in_rd_err
      && in_rd_data == 16'h0000) else $error("unmapped read");
   diag_map_a: assert property (in_rd_en && in_rd_addr == 3'h5 |=> in_rd_data ==
      {8'h00, $past(do_overload | do_short | do_open, 2)}) else $error("flag byte");
   stat_map_a: assert property (in_rd_en && in_rd_addr == 3'h4 |=> in_rd_data ==
      {8'h00, $past(spec_status)}) else $error("status byte");
   sw_write_a: assert property (out_wr_en && out_wr_addr == 3'h5 && out_wr_be[0] |=>
      do_switch == $past(out_wr_data[7:0])) else $error("switch byte");
   sw_hold_a: assert property (!(out_wr_en && out_wr_addr == 3'h5 && out_wr_be[0]) |=>
      $stable(do_switch)) else $error("switch moved");
   ao_write_a: assert property (out_wr_en && out_wr_addr == 3'h0 && out_wr_be == 2'h3 |=>
      ao_value[15:0] == $past(out_wr_data)) else $error("analog word 0");
   ctrl_load_a: assert property (out_wr_en && out_wr_addr == 3'h4 && out_wr_be[0] |=>
      spec_ctrl_load ##0 spec_ctrl == $past(out_wr_data[7:0])) else $error("ctrl");
   wr_err_a: assert property (out_wr_en && out_wr_addr > 3'h5 |=> out_wr_err)
      else $error("no write error");
endmodule : iopim_mapper_chk
bind iopim_mapper iopim_mapper_chk #(.AO_CH(AO_CH)) u_iopim_mapper_chk (.clk(clk),
   .rst_b(rst_b), .in_rd_en(in_rd_en), .in_rd_addr(in_rd_addr), .in_rd_data(in_rd_data),
   .in_rd_valid(in_rd_valid), .in_rd_err(in_rd_err), .out_wr_en(out_wr_en),
   .out_wr_addr(out_wr_addr), .out_wr_be(out_wr_be), .out_wr_data(out_wr_data),
   .out_wr_err(out_wr_err), .do_overload(do_overload), .do_short(do_short),
   .do_open(do_open), .spec_status(spec_status), .ao_value(ao_value),
   .do_switch(do_switch), .spec_ctrl(spec_ctrl), .spec_ctrl_load(spec_ctrl_load));

// file: testbench/iopim_field_model.sv
/*
 Field side of the mapper: analog converters, output drivers, special module.
 Assumes the bench sets the wanted levels away from the rising edge.
*/
`timescale 1ns/100ps
module iopim_field_model (
   input wire logic [63:0] ai_next,
   input wire logic [23:0] flt_next,
   input wire logic [7:0] stat_next,
   output logic [63:0] ai_meas,
   output logic [7:0] do_overload,
   output logic [7:0] do_short,
   output logic [7:0] do_open,
   output logic [7:0] spec_status
);
   assign ai_meas = ai_next;
   assign do_overload = flt_next[7:0];
   assign do_short = flt_next[15:8];
   assign do_open = flt_next[23:16];
   assign spec_status = stat_next;
endmodule : iopim_field_model

// file: testbench/tb_io_process_image_mapper.sv
/*
 Self-checking bench of the process image mapper with default parameters, plus a one-channel input build.
 Assumes a 25 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module tb_io_process_image_mapper;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic in_rd_en = 1'b0, out_rd_en = 1'b0, out_wr_en = 1'b0;
   logic [2:0] in_rd_addr = 3'h0, out_rd_addr = 3'h0, out_wr_addr = 3'h0;
   logic [1:0] out_wr_be = 2'h0;
   logic [15:0] out_wr_data = 16'h0000, in_rd_data, out_rd_data, d, w;
   logic in_rd_valid, in_rd_err, out_wr_err, out_rd_valid, out_rd_err, spec_ctrl_load, e;
   logic [63:0] ai_next = 64'h0, ai_meas, ao_value;
   logic [23:0] flt = 24'h0;
   logic [7:0] stat = 8'h00, do_overload, do_short, do_open, spec_status, do_switch, spec_ctrl;
   logic [31:0] s = 32'h6543;
   logic [15:0] img [0:5];
   int mismatches = 0, cmp_count = 0;
   logic one_rd_en = 1'b0, one_rd_valid;
   logic [15:0] one_rd_data;
   always #20 clk = ~clk;
   iopim_field_model u_iopim_field_model (.ai_next(ai_next), .flt_next(flt),
      .stat_next(stat), .ai_meas(ai_meas), .do_overload(do_overload), .do_short(do_short),
      .do_open(do_open), .spec_status(spec_status));
   iopim_mapper u_iopim_mapper (.clk(clk), .rst_b(rst_b), .in_rd_en(in_rd_en),
      .in_rd_addr(in_rd_addr), .in_rd_data(in_rd_data), .in_rd_valid(in_rd_valid),
      .in_rd_err(in_rd_err), .out_wr_en(out_wr_en), .out_wr_addr(out_wr_addr),
      .out_wr_be(out_wr_be), .out_wr_data(out_wr_data), .out_wr_err(out_wr_err),
      .out_rd_en(out_rd_en), .out_rd_addr(out_rd_addr), .out_rd_data(out_rd_data),
      .out_rd_valid(out_rd_valid), .out_rd_err(out_rd_err), .ai_meas(ai_meas),
      .do_overload(do_overload), .do_short(do_short), .do_open(do_open),
      .spec_status(spec_status), .ao_value(ao_value), .do_switch(do_switch),
      .spec_ctrl(spec_ctrl), .spec_ctrl_load(spec_ctrl_load));
   // One-channel input build: differential word first, reference word second
   iopim_mapper #(.AI_CH(1)) u_iopim_mapper_one (.clk(clk), .rst_b(rst_b),
      .in_rd_en(one_rd_en), .in_rd_addr(in_rd_addr), .in_rd_data(one_rd_data),
      .in_rd_valid(one_rd_valid), .in_rd_err(), .out_wr_en(1'b0), .out_wr_addr(3'h0),
      .out_wr_be(2'h0), .out_wr_data(16'h0000), .out_wr_err(), .out_rd_en(1'b0),
      .out_rd_addr(3'h0), .out_rd_data(), .out_rd_valid(), .out_rd_err(),
      .ai_meas(ai_meas[31:0]), .do_overload(do_overload), .do_short(do_short),
      .do_open(do_open), .spec_status(spec_status), .ao_value(), .do_switch(),
      .spec_ctrl(), .spec_ctrl_load());
   function automatic logic [31:0] nx(input logic [31:0] v);
      nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nx
   // Merge a write into the expected word; byte-wide words keep a zero high byte
   function automatic logic [15:0] upd(input logic [15:0] o, input logic [1:0] be,
                                       input logic [15:0] v, input int a);
      upd = {be[1] ? v[15:8] : o[15:8], be[0] ? v[7:0] : o[7:0]};
      if (a > 3) upd[15:8] = 8'h00;
   endfunction : upd
   task automatic rd(input logic img_out, input logic [2:0] a);
      @(negedge clk);
      in_rd_en = !img_out;
      out_rd_en = img_out;
      in_rd_addr = a;
      out_rd_addr = a;
      @(negedge clk);
      in_rd_en = 1'b0;
      out_rd_en = 1'b0;
      d = img_out ? out_rd_data : in_rd_data;
      e = img_out ? out_rd_err : in_rd_err;
      `CHK(img_out ? out_rd_valid : in_rd_valid, 1'b1)
   endtask : rd
   task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] v);
      @(negedge clk);
      out_wr_en = 1'b1;
      out_wr_addr = a;
      out_wr_be = be;
      out_wr_data = v;
      @(negedge clk);
      out_wr_en = 1'b0;
      e = out_wr_err;
      if (a < 3'h6) img[a] = upd(img[a], be, v, a);
   endtask : wr
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      for (int i = 0; i < 6; i++) img[i] = 16'h0000;
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      `CHK({ao_value, do_switch, spec_ctrl}, 80'h0)
      rd(1'b0, 3'h5);
      `CHK(d, 16'h0000)
      $display("test reset done");
      s = nx(s);
      ai_next[31:0] = s;
      s = nx(s);
      ai_next[63:32] = s;
      stat = s[15:8];
      for (int i = 0; i < 4; i++) begin
         rd(1'b0, i[2:0]);
         `CHK(d, ai_next[16*i+:16])
      end
      for (int i = 0; i < 2; i++) begin
         @(negedge clk);
         one_rd_en = 1'b1;
         in_rd_addr = i[2:0];
         @(negedge clk);
         one_rd_en = 1'b0;
         `CHK({one_rd_valid, one_rd_data}, {1'b1, ai_next[16*i+:16]})
      end
      rd(1'b0, 3'h4);
      `CHK(d, {8'h00, stat})
      for (int k = 0; k < 9; k++) begin
         s = nx(s);
         flt = (k < 8) ? 24'h1 << (k + 8 * (k % 3)) : s[23:0];
         rd(1'b0, 3'h5);
         `CHK(d, {8'h00, flt[7:0] | flt[15:8] | flt[23:16]})
      end
      rd(1'b0, 3'h6);
      `CHK({e, d}, 17'h10000)
      $display("test input image done");
      wr(3'h5, 2'h3, 16'hA55A);
      wr(3'h2, 2'h2, 16'hC3F0);
      wr(3'h7, 2'h3, 16'hFFFF);
      `CHK(e, 1'b1)
      for (int i = 0; i < 24; i++) begin
         s = nx(s);
         wr(s[2:0] % 3'h6, s[4:3], s[31:16]);
      end
      `CHK(ao_value, {img[3], img[2], img[1], img[0]})
      `CHK(spec_ctrl, img[4][7:0])
      `CHK(do_switch, img[5][7:0])
      for (int i = 0; i < 6; i++) begin
         rd(1'b1, i[2:0]);
         `CHK(d, img[i])
      end
      rd(1'b1, 3'h7);
      `CHK({e, d}, 17'h10000)
      $display("test output image done");
      // Reset in mid-run must drop every output word written above
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      `CHK({ao_value, do_switch, spec_ctrl, out_rd_data}, 96'h0)
      rd(1'b1, 3'h5);
      `CHK(d, 16'h0000)
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb_io_process_image_mapper
